// ### mcca_config_access.sv
`timescale 1ns/1ps
// Overview of operation
// - reset serial interface after cs low and sclk still for about 2 s
// - when filtering enabled, drop input pulses shorter than 200 ns
// - host sends a 7-bit command address; device decodes it
// - a direct command acts, accepts written data, or returns data
// - subcommands reached through the same space give multi-byte transfers
// - at power-up copy OTP settings into RAM config registers
// - config held unchanged in normal, sleep and retention states
// - entering power-off clears all config memory
// - next power-up restores factory defaults or programmed OTP
// - check memory at power-up, watch slow oscillator, run watchdog
// - factory defaults such as active interface depend on version
// - full update halts operation, resumes with new settings after
module mcca_config_access
  import mcca_pkg::*;
#(
  parameter int unsigned BUS_RST_CYCLES = BUS_RST_CYC,
  parameter int unsigned WDOG_CYCLES = WDOG_CYC,
  parameter logic [1:0] VERSION = 2'h0
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic filter_en,
  input wire mcca_pkg::mcca_serial_t serial_in,
  output logic miso,
  output logic miso_oe_n,
  input wire mcca_pkg::mcca_pwr_t pwr_state,
  input wire logic unrestricted_access_level,
  input wire logic otp_programmed,
  output logic otp_rd_en,
  output logic [4:0] otp_rd_addr,
  input wire logic [7:0] otp_rd_data,
  input wire logic [7:0] otp_sum,
  input wire logic slow_oscillator_tick,
  input wire logic cpu_kick,
  output logic [255:0] cfg_out,
  output mcca_pkg::mcca_status_t status
);
  import mcca_pkg::*;

  logic [2:0] filt;
  logic cs_f, sclk_f, mosi_f;
  mcca_state_t st_q, st_d;
  logic [5:0] idx_q, idx_d;
  logic [7:0] sum_q, sum_d;
  logic [7:0] cfg_q [CFG_DEPTH];
  logic [7:0] cfg_d [CFG_DEPTH];
  logic [7:0] sub_q, sub_d;
  logic memf_q, memf_d;
  logic sclk_p_q, sclk_p_d, first_q, first_d, wr_q, wr_d;
  logic abort_q, abort_d, miso_q, miso_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, tx_q, tx_d, byte_in;
  logic [6:0] addr_q, addr_d;
  logic [27:0] idle_q, idle_d;
  logic wr_en, cmd_done, rise, fall;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic [11:0] osc_q, osc_d;
  logic oscf_q, oscf_d, wdx_q, wdx_d;
  logic [23:0] wd_q, wd_d;

  // input conditioning
  generate
    for (genvar i = 0; i < 3; i++)
    begin : g_filt
      mcca_glitch_filter #(.RST_VAL(i == 2)) u_filt (
        .clock(clock),
        .rst(rst),
        .en(filter_en),
        .din(serial_in[i]),
        .dout(filt[i])
      );
    end
  endgenerate
  assign mosi_f = filt[0];
  assign sclk_f = filt[1];
  assign cs_f = filt[2];

  function automatic logic [7:0] dflt(input logic [4:0] i);
    dflt = (i == 5'h00) ? DFLT_IFACE[VERSION] : 8'h00;
  endfunction

  function automatic logic in_rng(input logic [6:0] a, lo, hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [7:0] rd_byte(input logic [6:0] a);
    logic [4:0] i;
    i = a[4:0];
    if (in_rng(a, A_DIRECT_LO, A_DIRECT_HI))
      rd_byte = cfg_q[i];
    else if (a == A_STATUS)
      rd_byte = {1'b0, status};
    else if (a == A_SUBCMD)
      rd_byte = sub_q;
    else if (in_rng(a, A_BLOCK_LO, A_BLOCK_HI) && sub_q == SUB_CFG)
      rd_byte = cfg_q[i];
    else if (in_rng(a, A_BLOCK_LO, A_BLOCK_HI) && sub_q == SUB_DIAG)
      rd_byte = (i == 5'h00) ? sum_q : {1'b0, status};
    else
      rd_byte = 8'h00;
  endfunction

  // serial command engine
  assign rise = sclk_f & ~sclk_p_q;
  assign fall = ~sclk_f & sclk_p_q;
  assign byte_in = {sh_q[6:0], mosi_f};

  always_comb
  begin
    sclk_p_d = sclk_f;
    first_d = first_q;
    wr_d = wr_q;
    abort_d = abort_q;
    miso_d = miso_q;
    bit_d = bit_q;
    sh_d = sh_q;
    tx_d = tx_q;
    addr_d = addr_q;
    idle_d = idle_q;
    wr_en = 1'b0;
    cmd_done = 1'b0;
    wr_addr = addr_q;
    wr_data = byte_in;
    if (cs_f || rise || fall)
      idle_d = 28'h0000000;
    else if (idle_q != 28'(BUS_RST_CYCLES))
      idle_d = idle_q + 28'h0000001;
    if (cs_f)
    begin
      first_d = 1'b1;
      bit_d = 3'h0;
      abort_d = 1'b0;
      tx_d = 8'h00;
      miso_d = 1'b0;
    end
    else if (idle_q == 28'(BUS_RST_CYCLES) || abort_q)
    begin
      abort_d = 1'b1;
      first_d = 1'b1;
      bit_d = 3'h0;
      tx_d = 8'h00;
      miso_d = 1'b0;
    end
    else if (rise)
    begin
      sh_d = byte_in;
      bit_d = bit_q + 3'h1;
      if (bit_q == 3'h7)
      begin
        if (first_q)
        begin
          first_d = 1'b0;
          wr_d = byte_in[7];
          addr_d = byte_in[6:0];
          cmd_done = 1'b1;
          tx_d = rd_byte(byte_in[6:0]);
        end
        else if (wr_q)
        begin
          wr_en = 1'b1;
          addr_d = addr_q + 7'h01;
        end
        else
        begin
          addr_d = addr_q + 7'h01;
          tx_d = rd_byte(addr_q + 7'h01);
        end
      end
    end
    else if (fall)
    begin
      miso_d = tx_q[7];
      tx_d = {tx_q[6:0], 1'b0};
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      sclk_p_q <= 1'b0;
      first_q <= 1'b1;
      wr_q <= 1'b0;
      abort_q <= 1'b0;
      miso_q <= 1'b0;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      addr_q <= 7'h00;
      idle_q <= 28'h0000000;
    end
    else
    begin
      sclk_p_q <= sclk_p_d;
      first_q <= first_d;
      wr_q <= wr_d;
      abort_q <= abort_d;
      miso_q <= miso_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      addr_q <= addr_d;
      idle_q <= idle_d;
    end
  end

  // configuration loader and power state handling
  always_comb
  begin
    st_d = st_q;
    idx_d = idx_q;
    sum_d = sum_q;
    sub_d = sub_q;
    memf_d = memf_q;
    cfg_d = cfg_q;
    otp_rd_en = 1'b0;
    otp_rd_addr = idx_q[4:0];
    case (st_q)
      ST_LOAD:
      begin
        otp_rd_en = otp_programmed && idx_q != CFG_LAST;
        if (idx_q != 6'h00)
        begin
          cfg_d[idx_q[4:0] - 5'h01] = otp_programmed ? otp_rd_data
                                      : dflt(idx_q[4:0] - 5'h01);
          if (otp_programmed)
            sum_d = sum_q + otp_rd_data;
        end
        if (idx_q == CFG_LAST)
        begin
          memf_d = otp_programmed && (sum_d != otp_sum);
          st_d = ST_RUN;
        end
        else
          idx_d = idx_q + 6'h01;
      end
      ST_RUN, ST_UPDATE:
      begin
        if (wr_en && in_rng(wr_addr, A_DIRECT_LO, A_DIRECT_HI)
            && (st_q == ST_UPDATE || wr_addr[4:0] < CFG_LIVE_N))
          cfg_d[wr_addr[4:0]] = wr_data;
        else if (wr_en && wr_addr == A_SUBCMD)
          sub_d = wr_data;
        else if (wr_en && in_rng(wr_addr, A_BLOCK_LO, A_BLOCK_HI)
                 && sub_q == SUB_CFG && st_q == ST_UPDATE)
          cfg_d[wr_addr[4:0]] = wr_data;
        if (cmd_done && addr_d == A_ENTER_UPD && unrestricted_access_level)
          st_d = ST_UPDATE;
        else if (cmd_done && addr_d == A_EXIT_UPD)
          st_d = ST_RUN;
        else if (cmd_done && addr_d == A_RELOAD && st_q == ST_UPDATE)
        begin
          st_d = ST_LOAD;
          idx_d = 6'h00;
          sum_d = 8'h00;
        end
      end
      ST_CLEAR:
      begin
        for (int i = 0; i < CFG_DEPTH; i++)
          cfg_d[i] = 8'h00;
        st_d = ST_OFF;
      end
      ST_OFF:
      begin
        if (pwr_state != PWR_OFF)
        begin
          st_d = ST_LOAD;
          idx_d = 6'h00;
          sum_d = 8'h00;
          sub_d = SUB_CFG;
        end
      end
      default:
        st_d = ST_CLEAR;
    endcase
    if (pwr_state == PWR_OFF && st_q != ST_OFF && st_q != ST_CLEAR)
      st_d = ST_CLEAR;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      st_q <= ST_LOAD;
      idx_q <= 6'h00;
      sum_q <= 8'h00;
      sub_q <= SUB_CFG;
      memf_q <= 1'b0;
      for (int i = 0; i < CFG_DEPTH; i++)
        cfg_q[i] <= 8'h00;
    end
    else
    begin
      st_q <= st_d;
      idx_q <= idx_d;
      sum_q <= sum_d;
      sub_q <= sub_d;
      memf_q <= memf_d;
      cfg_q <= cfg_d;
    end
  end

  // slow oscillator monitor and processor watchdog
  always_comb
  begin
    osc_d = osc_q;
    oscf_d = oscf_q;
    wd_d = wd_q;
    wdx_d = wdx_q;
    if (slow_oscillator_tick)
    begin
      osc_d = 12'h000;
      if (osc_q < OSC_MIN_CYC || osc_q > OSC_MAX_CYC)
        oscf_d = 1'b1;
    end
    else if (osc_q <= OSC_MAX_CYC)
      osc_d = osc_q + 12'h001;
    else
      oscf_d = 1'b1;
    if (cpu_kick)
      wd_d = 24'h000000;
    else if (wd_q == 24'(WDOG_CYCLES))
      wdx_d = 1'b1;
    else
      wd_d = wd_q + 24'h000001;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      osc_q <= 12'h000;
      oscf_q <= 1'b0;
      wd_q <= 24'h000000;
      wdx_q <= 1'b0;
    end
    else
    begin
      osc_q <= osc_d;
      oscf_q <= oscf_d;
      wd_q <= wd_d;
      wdx_q <= wdx_d;
    end
  end

  generate
    for (genvar i = 0; i < CFG_DEPTH; i++)
    begin : g_cfg
      assign cfg_out[i*8 +: 8] = cfg_q[i];
    end
  endgenerate

  assign miso = miso_q;
  assign miso_oe_n = cs_f;
  assign status.operating = (st_q == ST_RUN);
  assign status.update_active = (st_q == ST_UPDATE);
  assign status.loading = (st_q == ST_LOAD);
  assign status.mem_fault = memf_q;
  assign status.osc_fault = oscf_q;
  assign status.wdog_expired = wdx_q;
  assign status.bus_timeout = abort_q;
endmodule // mcca_config_access

// ### mcca_pkg.sv
package mcca_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CLK_PER_US = CLK_HZ / 1_000_000;
  // input glitch filter window, ns
  localparam int unsigned FILT_NS = 200;
  localparam int unsigned FILT_CYC = (FILT_NS * CLK_PER_US + 999) / 1000;
  // bus idle reset, least time 1.9 s held in tenths of a second
  localparam int unsigned BUS_RST_S_X10 = 19;
  localparam int unsigned BUS_RST_CYC = BUS_RST_S_X10 * (CLK_HZ / 10);
  // processor watchdog timeout, ms
  localparam int unsigned WDOG_MS = 100;
  localparam int unsigned WDOG_CYC = WDOG_MS * (CLK_HZ / 1000);
  // slow oscillator tick spacing window, clock cycles
  localparam logic [11:0] OSC_MIN_CYC = 12'h0b54;
  localparam logic [11:0] OSC_MAX_CYC = 12'h0c80;
  localparam int unsigned CFG_DEPTH = 32;
  localparam logic [5:0] CFG_LAST = 6'h20;
  // number of config bytes writable while operating
  localparam logic [4:0] CFG_LIVE_N = 5'h04;
  // command address map
  localparam logic [6:0] A_DIRECT_LO = 7'h00;
  localparam logic [6:0] A_DIRECT_HI = 7'h07;
  localparam logic [6:0] A_STATUS = 7'h08;
  localparam logic [6:0] A_SUBCMD = 7'h3e;
  localparam logic [6:0] A_BLOCK_LO = 7'h40;
  localparam logic [6:0] A_BLOCK_HI = 7'h5f;
  localparam logic [6:0] A_ENTER_UPD = 7'h70;
  localparam logic [6:0] A_EXIT_UPD = 7'h71;
  localparam logic [6:0] A_RELOAD = 7'h72;
  // subcommands selecting the block area
  localparam logic [7:0] SUB_CFG = 8'h00;
  localparam logic [7:0] SUB_DIAG = 8'h01;
  // factory default for config byte 0 (active interface) per version
  localparam logic [7:0] DFLT_IFACE [4] = '{8'h01, 8'h02, 8'h03, 8'h01};

  typedef enum logic [3:0] {
    PWR_NORMAL = 4'b0001,
    PWR_SLEEP = 4'b0010,
    PWR_RETENTION = 4'b0100,
    PWR_OFF = 4'b1000
  } mcca_pwr_t;

  typedef enum logic [4:0] {
    ST_LOAD = 5'b00001,
    ST_RUN = 5'b00010,
    ST_UPDATE = 5'b00100,
    ST_CLEAR = 5'b01000,
    ST_OFF = 5'b10000
  } mcca_state_t;

  typedef struct packed {
    logic operating;
    logic update_active;
    logic loading;
    logic mem_fault;
    logic osc_fault;
    logic wdog_expired;
    logic bus_timeout;
  } mcca_status_t;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic mosi;
  } mcca_serial_t;
endpackage

// ### mcca_glitch_filter.sv
`timescale 1ns/1ps
module mcca_glitch_filter
  import mcca_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic en,
  input wire logic din,
  output logic dout
);
  logic dout_q, dout_d;
  logic [4:0] cnt_q, cnt_d;

  always_comb
  begin
    dout_d = dout_q;
    cnt_d = 5'h00;
    if (din != dout_q)
    begin
      if (!en || cnt_q == 5'(FILT_CYC - 1))
        dout_d = din;
      else
        cnt_d = cnt_q + 5'h01;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      dout_q <= RST_VAL;
      cnt_q <= 5'h00;
    end
    else
    begin
      dout_q <= dout_d;
      cnt_q <= cnt_d;
    end
  end

  assign dout = dout_q;
endmodule // mcca_glitch_filter

// ### mcca_properties.sv
`timescale 1ns/1ps
module mcca_properties
  import mcca_pkg::*;
#(
  parameter int unsigned BUS_RST_CYCLES = 200,
  parameter int unsigned WDOG_CYCLES = 500
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic filter_en,
  input wire mcca_pkg::mcca_serial_t serial_in,
  input wire logic miso,
  input wire logic miso_oe_n,
  input wire mcca_pkg::mcca_pwr_t pwr_state,
  input wire logic unrestricted_access_level,
  input wire logic otp_programmed,
  input wire logic otp_rd_en,
  input wire logic [4:0] otp_rd_addr,
  input wire logic [7:0] otp_rd_data,
  input wire logic [7:0] otp_sum,
  input wire logic slow_oscillator_tick,
  input wire logic cpu_kick,
  input wire logic [255:0] cfg_out,
  input wire mcca_pkg::mcca_status_t status
);
  int idle_q;
  int idle_d;
  int kick_q;
  int kick_d;
  logic sclk_q;
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  // cycles with cs low and sclk still, cycles since last kick
  always_comb
  begin
    idle_d = idle_q + 1;
    kick_d = kick_q + 1;
    if (serial_in.cs_n || serial_in.sclk != sclk_q)
      idle_d = 0;
    if (cpu_kick)
      kick_d = 0;
  end
  always_ff @(posedge clock)
  begin
    idle_q <= rst ? 0 : idle_d;
    kick_q <= rst ? 0 : kick_d;
    sclk_q <= serial_in.sclk;
  end
  boot_load_a: assert property ($fell(rst) |-> status.loading
    ##[30:40] status.operating) else $error("load length");
  otp_gate_a: assert property (otp_rd_en |-> otp_programmed
    && status.loading) else $error("otp read outside load");
  otp_step_a: assert property (otp_rd_en && $past(otp_rd_en)
    && otp_rd_addr != 5'h00 |-> otp_rd_addr == $past(otp_rd_addr) + 5'h01)
    else $error("otp address order");
  off_clear_a: assert property (pwr_state == PWR_OFF
    && status.operating |-> ##[1:3] cfg_out == 256'h0)
    else $error("config not cleared");
  run_hold_a: assert property (status.operating
    && $past(status.operating) |-> $stable(cfg_out[255:32]))
    else $error("config changed while running");
  upd_excl_a: assert property (status.update_active
    |-> !status.operating && !status.loading) else $error("update overlap");
  upd_key_a: assert property ($rose(status.update_active)
    |-> unrestricted_access_level) else $error("update without access");
  idle_late_a: assert property (idle_q == BUS_RST_CYCLES + 30
    |-> status.bus_timeout) else $error("bus reset missing");
  idle_early_a: assert property ($rose(status.bus_timeout)
    |-> idle_q >= BUS_RST_CYCLES) else $error("bus reset early");
  oe_off_a: assert property ($rose(serial_in.cs_n)
    |-> ##[1:24] miso_oe_n) else $error("miso still driven");
  wdog_late_a: assert property (kick_q == WDOG_CYCLES + 4
    |-> status.wdog_expired) else $error("watchdog missing");
  cover property ($rose(status.update_active));
  cover property ($rose(status.bus_timeout));
  cover property (pwr_state == PWR_OFF ##2 cfg_out == 256'h0);
endmodule // mcca_properties

bind mcca_config_access mcca_properties #(
  .BUS_RST_CYCLES(BUS_RST_CYCLES), .WDOG_CYCLES(WDOG_CYCLES)) chk (
  .clock(clock), .rst(rst), .filter_en(filter_en), .serial_in(serial_in),
  .miso(miso), .miso_oe_n(miso_oe_n), .pwr_state(pwr_state),
  .unrestricted_access_level(unrestricted_access_level),
  .otp_programmed(otp_programmed), .otp_rd_en(otp_rd_en),
  .otp_rd_addr(otp_rd_addr), .otp_rd_data(otp_rd_data), .otp_sum(otp_sum),
  .slow_oscillator_tick(slow_oscillator_tick), .cpu_kick(cpu_kick),
  .cfg_out(cfg_out), .status(status));

// ### mcca_host.sv
`timescale 1ns/1ps
module mcca_host
  import mcca_pkg::*;
(
  input wire logic clock,
  input wire logic miso,
  output mcca_pkg::mcca_serial_t ser
);
  localparam int HALF = 30;
  initial
  begin
    ser = 3'b100;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // cs low with the serial clock held still; cs stays low
  task automatic stall(input int n);
    ser.cs_n = 1'b0;
    tick(n);
  endtask
  task automatic end_frame();
    ser.cs_n = 1'b1;
    tick(HALF);
  endtask
  // short serial clock pulse inside a frame, below the filter window
  task automatic glitch(input int n);
    ser.cs_n = 1'b0;
    tick(HALF);
    ser.sclk = 1'b1;
    tick(n);
    ser.sclk = 1'b0;
    tick(HALF);
  endtask
  // one frame, mode 0, msb first
  task automatic xfer(input logic [7:0] tx[$], output logic [7:0] rx[$]);
    logic [7:0] b;
    rx = {};
    ser.cs_n = 1'b0;
    foreach (tx[i])
    begin
      for (int k = 7; k >= 0; k--)
      begin
        ser.mosi = tx[i][k];
        tick(HALF);
        ser.sclk = 1'b1;
        b[k] = miso;
        tick(HALF);
        ser.sclk = 1'b0;
      end
      rx.push_back(b);
    end
    tick(HALF);
    ser.cs_n = 1'b1;
    ser.mosi = ~ser.mosi;
    tick(HALF);
  endtask
endmodule // mcca_host

// ### mcca_config_access_bench.sv
`timescale 1ns/1ps
module mcca_config_access_bench;
  import mcca_pkg::*;
  logic clock = 1'b0;
  logic rst;
  logic filter_en;
  logic unrestricted_access_level;
  mcca_serial_t ser;
  logic miso;
  logic miso_oe_n;
  mcca_pwr_t pwr_state;
  logic otp_programmed;
  logic otp_rd_en;
  logic [4:0] otp_rd_addr;
  logic [7:0] otp_rd_data;
  logic [7:0] otp_sum;
  logic osc_tick;
  logic cpu_kick;
  logic kick_on = 1'b1;
  logic [255:0] cfg_out;
  mcca_status_t status;
  logic [31:0] seed = 32'h0000002d;
  logic [7:0] otp_mem [32];
  logic [7:0] tx[$];
  logic [7:0] rx[$];
  int m [32];
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  always #5 clock = ~clock;
  mcca_config_access #(.BUS_RST_CYCLES(200), .WDOG_CYCLES(500),
    .VERSION(2'h1)) DUT (.clock(clock), .rst(rst), .filter_en(filter_en),
    .serial_in(ser), .miso(miso), .miso_oe_n(miso_oe_n),
    .pwr_state(pwr_state),
    .unrestricted_access_level(unrestricted_access_level),
    .otp_programmed(otp_programmed), .otp_rd_en(otp_rd_en),
    .otp_rd_addr(otp_rd_addr), .otp_rd_data(otp_rd_data),
    .otp_sum(otp_sum), .slow_oscillator_tick(osc_tick),
    .cpu_kick(cpu_kick), .cfg_out(cfg_out), .status(status));
  mcca_host host (.clock(clock), .miso(miso), .ser(ser));
  // one-cycle otp read, steady kicks and oscillator ticks
  always @(posedge clock)
  begin
    otp_rd_data <= otp_mem[otp_rd_addr];
    cyc <= cyc + 1;
    cpu_kick <= kick_on && (cyc % 97 == 0);
    osc_tick <= (cyc % 3072 == 3071);
  end
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic logic [255:0] mv();
    for (int i = 0; i < 32; i++)
      mv[8*i+:8] = m[i][7:0];
  endfunction
  task automatic check(input logic [255:0] seen, input logic [255:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (bad_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    rst = 1'b1;
    filter_en = 1'b0;
    unrestricted_access_level = 1'b0;
    pwr_state = PWR_NORMAL;
    otp_programmed = 1'b0;
    otp_sum = 8'h00;
    // production line image of the otp
    for (int i = 0; i < 32; i++)
    begin
      otp_mem[i] = xs();
      otp_sum += otp_mem[i];
      m[i] = 0;
    end
    m[0] = 2;
    host.tick(5);
    rst = 1'b0;
    host.tick(40);
    check(cfg_out, mv());
    check(status, 7'h40);
    check(miso_oe_n, 1'b1);
    host.xfer('{8'h00, 8'h00, 8'h00}, rx);
    check(rx[1], m[0]);
    check(rx[2], m[1]);
    filter_en = 1'b1;
    tx = '{8'h82};
    for (int i = 2; i < 6; i++)
    begin
      tx.push_back(xs());
      if (i < 4)
        m[i] = tx[i - 1];
    end
    host.glitch(10);
    host.xfer(tx, rx);
    host.xfer('{8'hc4, 8'h5a}, rx);
    filter_en = 1'b0;
    check(cfg_out, mv());
    unrestricted_access_level = 1'b1;
    host.xfer('{8'hbe, 8'h00}, rx);
    host.xfer('{8'hf0}, rx);
    check(status.update_active, 1'b1);
    check(status.operating, 1'b0);
    tx = '{8'hc0};
    for (int i = 0; i < 32; i++)
    begin
      m[i] = xs();
      tx.push_back(m[i][7:0]);
    end
    host.xfer(tx, rx);
    host.xfer('{8'hf1}, rx);
    check(status, 7'h40);
    check(cfg_out, mv());
    host.xfer('{8'h40, 8'h00, 8'h00}, rx);
    check(rx[2], m[1]);
    pwr_state = PWR_RETENTION;
    host.tick(50);
    check(cfg_out, mv());
    pwr_state = PWR_OFF;
    host.tick(10);
    check(cfg_out, 256'h0);
    otp_programmed = 1'b1;
    pwr_state = PWR_NORMAL;
    host.tick(60);
    for (int i = 0; i < 32; i++)
      m[i] = otp_mem[i];
    check(cfg_out, mv());
    check(status.mem_fault, 1'b0);
    host.xfer('{8'hbe, 8'h01}, rx);
    host.xfer('{8'h40, 8'h00, 8'h00}, rx);
    check(rx[1], otp_sum);
    check(rx[2], 8'h40);
    host.xfer('{8'h08, 8'h00}, rx);
    check(rx[1], 8'h40);
    host.stall(150);
    check(status.bus_timeout, 1'b0);
    check(miso_oe_n, 1'b0);
    host.end_frame();
    host.stall(300);
    check(status.bus_timeout, 1'b1);
    host.end_frame();
    check(status.bus_timeout, 1'b0);
    kick_on = 1'b0;
    host.tick(600);
    check(status.wdog_expired, 1'b1);
    summarize();
  end
  initial
  begin
    host.tick(90000);
    bad_count++;
    summarize();
  end
endmodule // mcca_config_access_bench
